/* hdl/hbr_baro_ctrl.sv */
`timescale 1ns/100ps
module hbr_baro_ctrl
    import hbr_pkg::*;
#(
    parameter int unsigned CONV_WAIT = CONV_WAIT_CYC,
    parameter logic [7:0]  TEMP_CMD  = TEMP_CMD_DEFAULT
) (
    // Clock and reset
    input  wire logic                core_clk,
    input  wire logic                rst_n,
    // User request
    input  wire logic                start_req,
    input  wire logic                meas_temp,
    // User answer
    output logic                     busy,
    output logic [RESULT_W-1:0]      result,
    output logic                     result_valid,
    output logic                     result_good,
    output logic                     nack_err,
    // Two-wire bus, open drain
    input  wire logic                scl_in,
    output logic                     scl_out,
    output logic                     scl_oe_n,
    input  wire logic                sda_in,
    output logic                     sda_out,
    output logic                     sda_oe_n,
    // Converter pins
    output logic                     mclk,
    output logic                     converter_clear_n
);

    localparam int unsigned WW = $clog2(CONV_WAIT + CLR_SETUP_CYC + 1);

    default clocking cb_core @(posedge core_clk);
    endclocking
    default disable iff (!rst_n);

    hbr_state_e          state_q;
    logic [3:0]          step_q;
    logic [1:0]          qtr_q;
    logic [3:0]          bit_q;
    logic [WW-1:0]       wait_q;
    logic [7:0]          shift_q;
    logic [RESULT_W-1:0] rx_q;
    logic                temp_q;
    logic                err_q;
    logic                seen_q;
    logic                busy_q;
    logic                clear_n_q;
    logic [RESULT_W-1:0] result_q;
    logic                result_valid_q;
    logic                result_good_q;
    logic                nack_err_q;
    logic                scl_oe_n_q;
    logic                sda_oe_n_q;
    logic                mclk_q;
    logic                pin_lo_q;

    logic                scl_s;
    logic                sda_s;
    logic                qtr_tick;
    logic                mclk_tick;

    // Bus pins pass two flops before any logic reads them
    hbr_sync2 #(.RST_VAL(1'b1)) u_sync_scl (
        .core_clk (core_clk),
        .rst_n    (rst_n),
        .async_in (scl_in),
        .sync_out (scl_s)
    );
    hbr_sync2 #(.RST_VAL(1'b1)) u_sync_sda (
        .core_clk (core_clk),
        .rst_n    (rst_n),
        .async_in (sda_in),
        .sync_out (sda_s)
    );
    hbr_tick_div #(.CYC(QTR_CYC)) u_qtr_div (
        .core_clk (core_clk),
        .rst_n    (rst_n),
        .tick     (qtr_tick)
    );
    hbr_tick_div #(.CYC(MCLK_HALF_CYC)) u_mclk_div (
        .core_clk (core_clk),
        .rst_n    (rst_n),
        .tick     (mclk_tick)
    );

    // Decode
    logic       accept_w;
    logic       act_w;
    logic       xfer_w;
    logic       qadv_w;
    logic       samp_w;
    logic       adv_w;
    logic       done_w;
    logic       rd_w;
    logic       stop_w;
    logic [3:0] nstep_w;
    logic       ncond_w;
    hbr_state_e nstate_w;
    logic [7:0] tx_next_w;
    logic       tx_bit_w;
    logic       scl_oe_n_d;
    logic       sda_oe_n_d;

    assign accept_w = (state_q == ST_IDLE) && start_req;
    assign xfer_w   = (state_q == ST_XFER);
    assign act_w    = (state_q == ST_COND) || xfer_w;
    // Released clock held low by the device stretches the high phase
    assign qadv_w   = act_w && qtr_tick && !(qtr_q == 2'd2 && !scl_s);
    assign samp_w   = xfer_w && qadv_w && (qtr_q == 2'd2);
    assign adv_w    = (act_w && qadv_w && (qtr_q == 2'd3) && (!xfer_w || bit_q == ACK_BIT))
                    || ((state_q == ST_WAIT) && (wait_q == '0));
    assign done_w   = adv_w && (step_q == STEP_STOP2);
    assign rd_w     = (step_q == STEP_RD_MSB) || (step_q == STEP_RD_LSB);
    assign stop_w   = (step_q == STEP_STOP1) || (step_q == STEP_STOP2);

    // A refused byte skips the rest and ends with STOP
    assign nstep_w  = (err_q && step_q < STEP_STOP2) ? STEP_STOP2 : step_q + 4'h1;
    assign ncond_w  = (nstep_w == STEP_START1) || (nstep_w == STEP_STOP1)
                    || (nstep_w == STEP_START2) || (nstep_w == STEP_RSTART)
                    || (nstep_w == STEP_STOP2);
    assign nstate_w = (nstep_w == STEP_DONE) ? ST_IDLE :
                      (nstep_w == STEP_CONV) ? ST_WAIT :
                      ncond_w ? ST_COND : ST_XFER;

    assign tx_next_w =
        (nstep_w == STEP_ADR_W1 || nstep_w == STEP_ADR_W2) ? ADDR_WR :
        (nstep_w == STEP_CMD_A)  ? CMD_PRES_A :
        (nstep_w == STEP_CMD_B)  ? (temp_q ? TEMP_CMD : CMD_PRES_B) :
        (nstep_w == STEP_CMD_RD) ? CMD_READ :
        (nstep_w == STEP_ADR_RD) ? ADDR_RD : RELEASE_BYTE;

    // Ack slot: released after writes, low after high byte, high after low byte
    assign tx_bit_w = rd_w ? ((bit_q == ACK_BIT) ? (step_q == STEP_RD_LSB) : 1'b1)
                           : ((bit_q == ACK_BIT) ? 1'b1 : shift_q[7]);

    assign scl_oe_n_d = !qadv_w        ? scl_oe_n_q :
                        (qtr_q == 2'd1) ? 1'b1 :
                        (qtr_q == 2'd3) ? (!xfer_w && stop_w) : scl_oe_n_q;
    assign sda_oe_n_d = !qadv_w ? sda_oe_n_q :
                        xfer_w  ? ((qtr_q == 2'd0) ? tx_bit_w : sda_oe_n_q) :
                        (qtr_q == 2'd0) ? !stop_w :
                        (qtr_q == 2'd2) ? stop_w : sda_oe_n_q;

    // Sequencer
    always_ff @(posedge core_clk or negedge rst_n) begin
        if (!rst_n) begin
            state_q <= ST_IDLE;
            step_q  <= STEP_START1;
            qtr_q   <= 2'h0;
            bit_q   <= 4'h0;
            wait_q  <= '0;
        end else begin
            case (state_q)
                ST_IDLE: begin
                    if (start_req) begin
                        state_q <= ST_CLRUP;
                        step_q  <= STEP_START1;
                        wait_q  <= WW'(CLR_SETUP_CYC - 1);
                    end
                end
                ST_CLRUP: begin
                    if (wait_q == '0) begin
                        state_q <= ST_COND;
                        qtr_q   <= 2'h0;
                    end else begin
                        wait_q <= wait_q - WW'(1);
                    end
                end
                ST_WAIT: begin
                    if (wait_q == '0) begin
                        state_q <= nstate_w;
                        step_q  <= nstep_w;
                        qtr_q   <= 2'h0;
                    end else begin
                        wait_q <= wait_q - WW'(1);
                    end
                end
                ST_COND, ST_XFER: begin
                    if (qadv_w) begin
                        qtr_q <= qtr_q + 2'h1;
                    end
                    if (adv_w) begin
                        state_q <= nstate_w;
                        step_q  <= nstep_w;
                        bit_q   <= 4'h0;
                        wait_q  <= WW'(CONV_WAIT - 1);
                    end else if (qadv_w && qtr_q == 2'd3) begin
                        bit_q <= bit_q + 4'h1;
                    end
                end
                default: state_q <= ST_IDLE;
            endcase
        end
    end

    // Shift data, MSB first both ways
    always_ff @(posedge core_clk or negedge rst_n) begin
        if (!rst_n) begin
            shift_q <= RELEASE_BYTE;
            rx_q    <= '0;
            temp_q  <= 1'b0;
            err_q   <= 1'b0;
        end else begin
            if (accept_w) begin
                temp_q <= meas_temp;
                err_q  <= 1'b0;
            end
            if (adv_w) begin
                shift_q <= tx_next_w;
            end else if (samp_w && !rd_w && bit_q != ACK_BIT) begin
                shift_q <= {shift_q[6:0], 1'b0};
            end
            if (samp_w && rd_w && bit_q != ACK_BIT) begin
                rx_q <= {rx_q[RESULT_W-2:0], sda_s};
            end
            if (samp_w && !rd_w && bit_q == ACK_BIT && sda_s) begin
                err_q <= 1'b1;
            end
        end
    end

    // Bus pins and converter pins
    always_ff @(posedge core_clk or negedge rst_n) begin
        if (!rst_n) begin
            scl_oe_n_q <= 1'b1;
            sda_oe_n_q <= 1'b1;
            mclk_q     <= 1'b0;
            pin_lo_q   <= 1'b0;
            clear_n_q  <= 1'b0;
        end else begin
            scl_oe_n_q <= scl_oe_n_d;
            sda_oe_n_q <= sda_oe_n_d;
            pin_lo_q   <= 1'b0;
            if (mclk_tick) begin
                mclk_q <= !mclk_q;
            end
            if (accept_w) begin
                clear_n_q <= 1'b1;
            end else if (done_w) begin
                clear_n_q <= 1'b0;
            end
        end
    end

    // User answer; first good reading is flagged for discard
    always_ff @(posedge core_clk or negedge rst_n) begin
        if (!rst_n) begin
            busy_q         <= 1'b0;
            result_q       <= '0;
            result_valid_q <= 1'b0;
            result_good_q  <= 1'b0;
            nack_err_q     <= 1'b0;
            seen_q         <= 1'b0;
        end else begin
            result_valid_q <= 1'b0;
            if (accept_w) begin
                busy_q     <= 1'b1;
                nack_err_q <= 1'b0;
            end else if (done_w) begin
                busy_q     <= 1'b0;
                nack_err_q <= err_q;
                if (!err_q) begin
                    result_q       <= rx_q;
                    result_valid_q <= 1'b1;
                    result_good_q  <= seen_q;
                    seen_q         <= 1'b1;
                end
            end
        end
    end

    assign busy              = busy_q;
    assign result            = result_q;
    assign result_valid      = result_valid_q;
    assign result_good       = result_good_q;
    assign nack_err          = nack_err_q;
    assign scl_out           = pin_lo_q;
    assign scl_oe_n          = scl_oe_n_q;
    assign sda_out           = pin_lo_q;
    assign sda_oe_n          = sda_oe_n_q;
    assign mclk              = mclk_q;
    assign converter_clear_n = clear_n_q;

    // Checks
    logic       data_slot_w;
    logic [2:0] bit_idx_w;

    assign data_slot_w = xfer_w && (qtr_q == 2'd2) && (bit_q < ACK_BIT);
    assign bit_idx_w   = 3'(4'h7 - bit_q);

    sequence s_ack_slot;
        xfer_w && (qtr_q == 2'd2) && (bit_q == ACK_BIT);
    endsequence
    sequence s_wait_entered;
        (state_q == ST_WAIT) && $past(state_q) != ST_WAIT;
    endsequence

    property p_addr_wr;
        data_slot_w && (step_q == STEP_ADR_W1 || step_q == STEP_ADR_W2)
            |-> sda_oe_n_q == ADDR_WR[bit_idx_w];
    endproperty
    a_addr_wr: assert property (p_addr_wr) else $error("write address bit wrong");
    property p_pres_sel;
        data_slot_w && !temp_q && (step_q == STEP_CMD_B) |-> sda_oe_n_q == CMD_PRES_B[bit_idx_w];
    endproperty
    a_pres_sel: assert property (p_pres_sel) else $error("pressure select bit wrong");
    property p_temp_sel;
        data_slot_w && temp_q && (step_q == STEP_CMD_B) |-> sda_oe_n_q == TEMP_CMD[bit_idx_w];
    endproperty
    a_temp_sel: assert property (p_temp_sel) else $error("temperature select bit wrong");
    property p_read_addr;
        data_slot_w && (step_q == STEP_ADR_RD) |-> sda_oe_n_q == ADDR_RD[bit_idx_w];
    endproperty
    a_read_addr: assert property (p_read_addr) else $error("read address bit wrong");
    property p_wait_load;
        s_wait_entered |-> (wait_q == WW'(CONV_WAIT - 1)) && scl_oe_n_q && sda_oe_n_q;
    endproperty
    a_wait_load: assert property (p_wait_load) else $error("conversion wait not loaded");
    property p_wait_count;
        (state_q == ST_WAIT) && (wait_q != '0)
            |=> (state_q == ST_WAIT) && (wait_q == $past(wait_q) - WW'(1));
    endproperty
    a_wait_count: assert property (p_wait_count) else $error("conversion wait cut short");
    // Data held low while the clock is released
    property p_ack_first;
        s_ack_slot ##0 (step_q == STEP_RD_MSB) |-> !sda_oe_n_q && scl_oe_n_q;
    endproperty
    a_ack_first: assert property (p_ack_first) else $error("high byte not acknowledged");
    property p_nack_last;
        s_ack_slot ##0 (step_q == STEP_RD_LSB) |-> sda_oe_n_q ##[1:400] (step_q == STEP_STOP2);
    endproperty
    a_nack_last: assert property (p_nack_last) else $error("low byte acknowledged or no stop");
    property p_clear_high;
        (state_q == ST_COND || state_q == ST_XFER || state_q == ST_WAIT) |-> converter_clear_n;
    endproperty
    a_clear_high: assert property (p_clear_high) else $error("clear low during conversion");
    property p_clear_low;
        $fell(busy_q) |-> !converter_clear_n ##1 (!converter_clear_n || busy_q);
    endproperty
    a_clear_low: assert property (p_clear_low) else $error("clear not low after conversion");
    property p_mclk_half;
        $changed(mclk_q) |=> $stable(mclk_q)[*8];
    endproperty
    a_mclk_half: assert property (p_mclk_half) else $error("measurement clock too fast");
    property p_first_drop;
        result_valid_q |-> result_good_q == $past(seen_q);
    endproperty
    a_first_drop: assert property (p_first_drop) else $error("first reading not flagged");

endmodule

/* hdl/hbr_pkg.sv */
package hbr_pkg;

    // Core timing
    localparam int unsigned CLK_HZ        = 20_000_000;
    localparam int unsigned SCL_HZ        = 100_000;
    localparam int unsigned QTR_CYC       = (CLK_HZ + 4 * SCL_HZ - 1) / (4 * SCL_HZ);
    localparam int unsigned MCLK_HZ       = 32_768;
    localparam int unsigned MCLK_HALF_CYC = CLK_HZ / (2 * MCLK_HZ);
    localparam int unsigned CONV_WAIT_MS  = 38;
    localparam int unsigned CONV_WAIT_CYC = CONV_WAIT_MS * (CLK_HZ / 1000);
    localparam int unsigned CLR_SETUP_CYC = 16;

    // Bus bytes
    localparam logic [7:0] ADDR_WR          = 8'hee;
    localparam logic [7:0] ADDR_RD          = 8'hef;
    localparam logic [7:0] CMD_PRES_A       = 8'hff;
    localparam logic [7:0] CMD_PRES_B       = 8'hf0;
    localparam logic [7:0] CMD_READ         = 8'hfd;
    localparam logic [7:0] TEMP_CMD_DEFAULT = 8'h00;
    localparam logic [7:0] RELEASE_BYTE     = 8'hff;

    localparam int unsigned RESULT_W = 16;

    // Sequence steps
    localparam logic [3:0] STEP_START1 = 4'h0;
    localparam logic [3:0] STEP_ADR_W1 = 4'h1;
    localparam logic [3:0] STEP_CMD_A  = 4'h2;
    localparam logic [3:0] STEP_CMD_B  = 4'h3;
    localparam logic [3:0] STEP_STOP1  = 4'h4;
    localparam logic [3:0] STEP_CONV   = 4'h5;
    localparam logic [3:0] STEP_START2 = 4'h6;
    localparam logic [3:0] STEP_ADR_W2 = 4'h7;
    localparam logic [3:0] STEP_CMD_RD = 4'h8;
    localparam logic [3:0] STEP_RSTART = 4'h9;
    localparam logic [3:0] STEP_ADR_RD = 4'ha;
    localparam logic [3:0] STEP_RD_MSB = 4'hb;
    localparam logic [3:0] STEP_RD_LSB = 4'hc;
    localparam logic [3:0] STEP_STOP2  = 4'hd;
    localparam logic [3:0] STEP_DONE   = 4'he;

    localparam logic [3:0] ACK_BIT = 4'h8;

    typedef enum logic [4:0] {
        ST_IDLE  = 5'b00001,
        ST_CLRUP = 5'b00010,
        ST_COND  = 5'b00100,
        ST_XFER  = 5'b01000,
        ST_WAIT  = 5'b10000
    } hbr_state_e;

endpackage

/* hdl/hbr_sync2.sv */
`timescale 1ns/100ps
module hbr_sync2 #(
    parameter logic RST_VAL = 1'b1
) (
    // Clock and reset
    input  wire logic core_clk,
    input  wire logic rst_n,
    // Data
    input  wire logic async_in,
    output logic      sync_out
);

    logic meta_q;
    logic sync_q;

    always_ff @(posedge core_clk or negedge rst_n) begin
        if (!rst_n) begin
            meta_q <= RST_VAL;
            sync_q <= RST_VAL;
        end else begin
            meta_q <= async_in;
            sync_q <= meta_q;
        end
    end

    assign sync_out = sync_q;

endmodule

/* hdl/hbr_tick_div.sv */
`timescale 1ns/100ps
module hbr_tick_div #(
    parameter int unsigned CYC = 2
) (
    // Clock and reset
    input  wire logic core_clk,
    input  wire logic rst_n,
    // One-cycle pulse every CYC cycles
    output logic      tick
);

    localparam int unsigned W = (CYC > 1) ? $clog2(CYC) : 1;

    logic [W-1:0] cnt_q;
    logic         tick_q;
    logic         wrap_w;

    assign wrap_w = (cnt_q == W'(CYC - 1));

    always_ff @(posedge core_clk or negedge rst_n) begin
        if (!rst_n) begin
            cnt_q  <= '0;
            tick_q <= 1'b0;
        end else begin
            cnt_q  <= wrap_w ? '0 : cnt_q + W'(1);
            tick_q <= wrap_w;
        end
    end

    assign tick = tick_q;

endmodule

/* tb/hbr_baro_ctrl_bench.sv */
`timescale 1ns/100ps
module hbr_baro_ctrl_bench
    import hbr_pkg::*;
;
    localparam int unsigned CW   = 1000;
    localparam logic [7:0]  TCMD = 8'h5a; // Arbitrary select byte
    logic        core_clk, rst_n, start_req, meas_temp, refuse, stretch;
    logic        busy, result_valid, result_good, nack_err, mclk, converter_clear_n;
    logic        scl_oe_n, sda_oe_n, d_scl_oe_n, d_sda_oe_n, clr_bad, prev;
    logic        scl_out, sda_out;
    logic [15:0] result, next_val, sel_cmd;
    logic [1:0]  macks;
    time         gap;
    int          n_errors, num_checks, n_good, hold, k, r, t;
    int          exp_q[$];
    // Open drain with pull-up
    wire         scl = (scl_oe_n === 1'b0 || d_scl_oe_n === 1'b0) ? 1'b0 : 1'b1;
    wire         sda = (sda_oe_n === 1'b0 || d_sda_oe_n === 1'b0) ? 1'b0 : 1'b1;

    hbr_baro_ctrl #(.CONV_WAIT(CW), .TEMP_CMD(TCMD)) dut (
        .core_clk(core_clk), .rst_n(rst_n), .start_req(start_req), .meas_temp(meas_temp),
        .busy(busy), .result(result), .result_valid(result_valid),
        .result_good(result_good), .nack_err(nack_err),
        .scl_in(scl), .scl_out(scl_out), .scl_oe_n(scl_oe_n),
        .sda_in(sda), .sda_out(sda_out), .sda_oe_n(sda_oe_n),
        .mclk(mclk), .converter_clear_n(converter_clear_n)
    );

    hbr_dev_model dev (
        .scl(scl), .sda(sda), .scl_oe_n(d_scl_oe_n), .sda_oe_n(d_sda_oe_n),
        .converter_clear_n(converter_clear_n), .next_val(next_val),
        .refuse(refuse), .stretch(stretch),
        .sel_cmd(sel_cmd), .macks(macks), .clr_bad(clr_bad), .gap(gap)
    );

    always #25 core_clk = ~core_clk;

    task automatic chk(input string nm, input logic [15:0] seen, input logic [15:0] exp);
        num_checks++;
        if (seen !== exp) begin
            n_errors++;
            $display("wrong value %s: expected %h seen %h", nm, exp, seen);
        end
    endtask

    task automatic complete_run();
        $display("checks %0d mismatches %0d", num_checks, n_errors);
        if (n_errors == 0 && num_checks > 0) begin
            $display("TB: PASS");
        end else begin
            $display("TB: FAIL");
        end
        $finish;
    endtask

    task automatic conv(input logic tmp, input logic slow, input logic bad);
        logic [15:0] v;
        int          e;
        int          n;
        v = 16'($urandom);
        exp_q.push_back(int'(v));
        @(negedge core_clk);
        next_val = v;
        refuse = bad;
        stretch = slow;
        meas_temp = tmp;
        start_req = 1'b1;
        @(negedge core_clk);
        start_req = 1'b0;
        repeat (300) @(negedge core_clk);
        chk("busy", busy, 16'h1);
        chk("clear_n", converter_clear_n, 16'h1);
        // Request while busy must be ignored
        start_req = 1'b1;
        @(negedge core_clk);
        start_req = 1'b0;
        n = 0;
        while (result_valid !== 1'b1 && busy === 1'b1 && n < 60000) begin
            @(negedge core_clk);
            n++;
        end
        if (n >= 60000) begin
            n_errors++;
            complete_run();
        end
        e = exp_q.pop_front();
        if (bad) begin
            chk("nack_err", nack_err, 16'h1);
            chk("valid", result_valid, 16'h0);
            chk("held", result, 16'(hold));
        end else begin
            chk("valid", result_valid, 16'h1);
            chk("result", result, 16'(e));
            chk("good", result_good, 16'(n_good > 0));
            chk("clear_low", converter_clear_n, 16'h0);
            chk("select", sel_cmd, {CMD_PRES_A, tmp ? TCMD : CMD_PRES_B});
            chk("acks", macks, 16'h1);
            chk("wait", 16'(gap >= CW * 50), 16'h1);
            hold = e;
            n_good++;
        end
        repeat (4) @(negedge core_clk);
        chk("idle", busy, 16'h0);
        chk("pins_low", {scl_out, sda_out}, 16'h0);
        $display("test done: temp %0d slow %0d refuse %0d", tmp, slow, bad);
    endtask

    initial begin
        {core_clk, rst_n, start_req, meas_temp, refuse, stretch} = '0;
        next_val = 16'h0;
        {n_errors, num_checks, n_good, hold} = '0;
        void'($urandom(53963));
        repeat (8) @(negedge core_clk);
        chk("reset", {busy, result_valid, result_good, nack_err, scl_oe_n, sda_oe_n,
            converter_clear_n, mclk, scl_out, sda_out}, 16'h030);
        chk("reset_result", result, 16'h0);
        rst_n = 1'b1;
        // Period of the measurement clock between two rising edges
        prev = mclk;
        {k, r, t} = '0;
        while (r < 2 && k < 2000) begin
            @(negedge core_clk);
            k++;
            if (mclk === 1'b1 && prev === 1'b0) begin
                r++;
                if (r == 1) t = k;
            end
            prev = mclk;
        end
        chk("mclk_period", 16'(k - t), 16'(2 * MCLK_HALF_CYC));
        $display("test done: mclk");
        conv(1'b0, 1'b0, 1'b0);
        conv(1'b1, 1'b1, 1'b0);
        conv(1'b0, 1'b0, 1'b1);
        conv(1'b0, 1'b1, 1'b0);
        conv(1'b1, 1'b0, 1'b0);
        chk("clear_hold", clr_bad, 16'h0);
        complete_run();
    end
endmodule

/* tb/hbr_dev_model.sv */
`timescale 1ns/100ps
module hbr_dev_model
    import hbr_pkg::*;
#(
    parameter logic HAS_CLR = 1'b1
) (
    // Bus wires
    input  wire logic        scl,
    input  wire logic        sda,
    output logic             scl_oe_n,
    output logic             sda_oe_n,
    // Converter pin and scenario control
    input  wire logic        converter_clear_n,
    input  wire logic [15:0] next_val,
    input  wire logic        refuse,
    input  wire logic        stretch,
    // Observations
    output logic [15:0]      sel_cmd,
    output logic [1:0]       macks,
    output logic             clr_bad,
    output time              gap
);
    logic [15:0] held;
    logic [7:0]  sh, b1;
    logic        act, rdm, armed;
    int          bitn, nbyte, idx;
    time         t_stop;
    wire         clr_eff = HAS_CLR ? converter_clear_n : 1'b1;
    // Inverted data unless the read command came first
    wire [15:0]  dval = armed ? held : ~held;

    initial begin
        {scl_oe_n, sda_oe_n, act, rdm, armed, clr_bad} = 6'h30;
        {held, sel_cmd, macks, sh, b1} = '0;
        {bitn, nbyte, idx, t_stop, gap} = '0;
    end

    always @(negedge sda) begin
        if (scl === 1'b1) begin
            if (!act) gap = $time - t_stop;
            act = 1'b1;
            rdm = 1'b0;
            // The host's own clock fall that closes START is not a data bit
            bitn = -1;
            nbyte = 0;
        end
    end

    always @(posedge sda) begin
        if (scl === 1'b1 && act) begin
            act = 1'b0;
            t_stop = $time;
        end
    end

    always @(posedge scl) begin
        if (act) begin
            if (converter_clear_n !== 1'b1) clr_bad = 1'b1;
            if (bitn < 8) sh = {sh[6:0], sda};
            else if (rdm) macks = {macks[0], sda};
        end
    end

    always @(negedge scl) begin
        if (act) begin
            bitn = bitn + 1;
            if (bitn == 9) begin
                bitn = 0;
                nbyte = nbyte + 1;
                rdm = rdm | (nbyte == 1 && sh == ADDR_RD && !refuse);
            end
            idx = 8 * nbyte - 8 + bitn;
            if (rdm) begin
                // High byte first, each byte MSB first
                sda_oe_n = (bitn == 8 || nbyte > 2) ? 1'b1 : dval[15 - idx];
            end else if (bitn == 8) begin
                sda_oe_n = refuse | !(nbyte > 0 || sh == ADDR_WR || sh == ADDR_RD);
                if (nbyte == 1) begin
                    b1 = sh;
                    armed = (sh == CMD_READ);
                end
                if (nbyte == 2) begin
                    sel_cmd = {b1, sh};
                    if (clr_eff) held = next_val;
                end
            end else begin
                sda_oe_n = 1'b1;
            end
        end
    end

    // Slow answer: hold the clock low after the host lowers it
    always @(negedge scl) begin
        if (stretch && act) begin
            scl_oe_n = 1'b0;
            // Longer than two quarters so the host really has to wait
            #9000;
            scl_oe_n = 1'b1;
        end
    end
endmodule
